// file: inc/cmp_regs_pkg.sv
// Package with the register map, reset values and command codes of the
// compression coprocessor host register bank.
// Assumes a byte-wide host register interface with a five-bit address.
package cmp_regs_pkg;

    // Register offsets, as seen with the address-swap mode low.
    localparam logic [4:0] OFS_STATUS_LOW      = 5'h00;
    localparam logic [4:0] OFS_STATUS_HIGH     = 5'h01;
    localparam logic [4:0] OFS_IDENT_LOW       = 5'h02;
    localparam logic [4:0] OFS_IDENT_HIGH      = 5'h03;
    localparam logic [4:0] OFS_COUNT_BYTE2     = 5'h04;
    localparam logic [4:0] OFS_COUNT_BYTE3     = 5'h05;
    localparam logic [4:0] OFS_COUNT_BYTE0     = 5'h06;
    localparam logic [4:0] OFS_COUNT_BYTE1     = 5'h07;
    localparam logic [4:0] OFS_GROUP8_LOW      = 5'h08;
    localparam logic [4:0] OFS_GROUP8_HIGH     = 5'h09;
    localparam logic [4:0] OFS_GROUPA_LOW      = 5'h0a;
    localparam logic [4:0] OFS_GROUPA_HIGH     = 5'h0b;
    localparam logic [4:0] OFS_COMMAND_LOW     = 5'h10;
    localparam logic [4:0] OFS_COMMAND_HIGH    = 5'h11;

    // Reset values.
    localparam logic [7:0]  RST_STATUS_LOW     = 8'h00;
    localparam logic [7:0]  RST_STATUS_HIGH    = 8'h0c;
    localparam logic [15:0] RST_CONFIG         = 16'h0000;
    localparam logic [7:0]  RST_PORT_A_POL     = 8'hff;
    localparam logic [7:0]  RST_PORT_B_POL     = 8'hdf;
    localparam logic [31:0] RST_COUNT          = 32'h0000_0000;
    localparam logic [15:0] RST_FIFO_WORD      = 16'h0000;
    localparam logic [7:0]  RST_FIFO_CONTROL   = 8'h00;
    localparam logic [15:0] RST_COMMAND        = 16'h0000;

    // Arbitrary identification values, not those of any real part.
    localparam logic [7:0]  IDENT_LOW_VALUE    = 8'h5a;
    localparam logic [7:0]  IDENT_HIGH_VALUE   = 8'ha5;

    // Command codes held in the high command byte.
    localparam logic [7:0]  CMD_RESET          = 8'h01;
    localparam logic [7:0]  CMD_SELECT_A       = 8'h02;
    localparam logic [7:0]  CMD_SELECT_B       = 8'h03;
    localparam logic [7:0]  CMD_NEW_TRANSFER   = 8'h04;

    // Bank selection following the last command.
    typedef enum logic [1:0] {BANK_STATUS, BANK_PORT_A, BANK_PORT_B} bank_t;

endpackage

// file: verilog/cmp_byte_pair.sv
// Sixteen-bit register written one byte at a time, updated as a whole.
// Assumes the caller flags a byte write and the byte lane it lands in.
`timescale 1ns/10ps
module cmp_byte_pair
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_clear,
    input  wire logic [15:0] i_clear_value,
    input  wire logic        i_wr,
    input  wire logic        i_hi,
    input  wire logic [7:0]  i_data,
    output logic      [15:0] o_value
);
    logic [7:0] low_hold_q;
    logic       low_seen_q;
    logic       commit;

    // The word changes only once both halves have come, low byte first.
    assign commit = i_wr && i_hi && low_seen_q;

    // Holding the low byte aside keeps logic from seeing a half-updated word.
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n || i_clear)
        begin
            o_value    <= i_clear_value;
            low_hold_q <= 8'h00;
            low_seen_q <= 1'b0;
        end
        else if (i_wr && !i_hi)
        begin
            low_hold_q <= i_data;
            low_seen_q <= 1'b1;
        end
        else if (commit)
        begin
            o_value    <= {i_data, low_hold_q};
            low_seen_q <= 1'b0;
        end
    end
endmodule // cmp_byte_pair

// file: verilog/cmp_parity_port.sv
// One sixteen-bit two-way data port with parity on each byte.
// Assumes the pin side samples inputs already synchronised.
`timescale 1ns/10ps
module cmp_parity_port
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [15:0] i_config,
    input  wire logic [7:0]  i_polarity,
    input  wire logic [15:0] i_out_data,
    input  wire logic [15:0] i_pin_data,
    input  wire logic [1:0]  i_pin_parity,
    output logic      [15:0] o_pin_data,
    output logic      [1:0]  o_pin_parity,
    output logic             o_pin_oe,
    output logic             o_parity_error
);
    logic [1:0] gen_parity;
    logic [1:0] chk_parity;
    logic       drive;
    logic       odd;

    // Config bit 0 turns the port into a driver; polarity bit 0 picks odd parity.
    assign drive      = i_config[0];
    assign odd        = i_polarity[0];
    assign gen_parity = {^i_out_data[15:8] ^ odd, ^i_out_data[7:0] ^ odd};
    assign chk_parity = {^i_pin_data[15:8] ^ odd, ^i_pin_data[7:0] ^ odd};

    // Parity is generated when driving and checked when receiving.
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            o_pin_data     <= 16'h0000;
            o_pin_parity   <= 2'b00;
            o_pin_oe       <= 1'b0;
            o_parity_error <= 1'b0;
        end
        else
        begin
            o_pin_data     <= i_out_data;
            o_pin_parity   <= gen_parity;
            o_pin_oe       <= drive;
            o_parity_error <= !drive && (chk_parity != i_pin_parity);
        end
    end
endmodule // cmp_parity_port

// file: verilog/cmp_reg_bank.sv
// Host register bank of the compression coprocessor with its two data ports.
// Assumes host strobes arrive from pins and pass a two-stage synchroniser.
`timescale 1ns/10ps
module cmp_reg_bank
    import cmp_regs_pkg::*;
(
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    input  wire logic [4:0]  I_ADDR,
    input  wire logic [7:0]  I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    input  wire logic        I_ADDRESS_SWAP_MODE,
    input  wire logic        I_A_XFER,
    input  wire logic        I_B_XFER,
    input  wire logic [15:0] I_A_PIN_DATA,
    input  wire logic [1:0]  I_A_PIN_PARITY,
    input  wire logic [15:0] I_B_PIN_DATA,
    input  wire logic [1:0]  I_B_PIN_PARITY,
    output logic      [7:0]  O_RDATA,
    output logic      [15:0] O_A_PIN_DATA,
    output logic      [1:0]  O_A_PIN_PARITY,
    output logic             O_A_PIN_OE,
    output logic      [15:0] O_B_PIN_DATA,
    output logic      [1:0]  O_B_PIN_PARITY,
    output logic             O_B_PIN_OE,
    output logic      [1:0]  O_PARITY_ERROR
);
    // Pin synchronisers; the first stage feeds only the second.
    logic [1:0] wr_s1_q, rd_s1_q, swap_s1_q, ax_s1_q, bx_s1_q;
    logic [1:0] wr_s2_q, rd_s2_q, swap_s2_q, ax_s2_q, bx_s2_q;
    logic       wr_prev_q;
    logic       rd_prev_q;
    logic [4:0] addr_s1_q, addr_s2_q;
    logic [7:0] wdata_s1_q, wdata_s2_q;
    logic [15:0] a_pin_s1_q, a_pin_s2_q, b_pin_s1_q, b_pin_s2_q;
    logic [1:0]  a_par_s1_q, a_par_s2_q, b_par_s1_q, b_par_s2_q;

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            wr_s1_q <= 2'b00; wr_s2_q <= 2'b00; rd_s1_q <= 2'b00; rd_s2_q <= 2'b00;
            swap_s1_q <= 2'b00; swap_s2_q <= 2'b00;
            ax_s1_q <= 2'b00; ax_s2_q <= 2'b00; bx_s1_q <= 2'b00; bx_s2_q <= 2'b00;
            addr_s1_q <= 5'h00; addr_s2_q <= 5'h00;
            wdata_s1_q <= 8'h00; wdata_s2_q <= 8'h00;
            a_pin_s1_q <= 16'h0000; a_pin_s2_q <= 16'h0000;
            b_pin_s1_q <= 16'h0000; b_pin_s2_q <= 16'h0000;
            a_par_s1_q <= 2'b00; a_par_s2_q <= 2'b00;
            b_par_s1_q <= 2'b00; b_par_s2_q <= 2'b00;
            wr_prev_q <= 1'b0; rd_prev_q <= 1'b0;
        end
        else
        begin
            wr_s1_q <= {1'b0, I_WR}; wr_s2_q <= wr_s1_q;
            rd_s1_q <= {1'b0, I_RD}; rd_s2_q <= rd_s1_q;
            swap_s1_q <= {1'b0, I_ADDRESS_SWAP_MODE}; swap_s2_q <= swap_s1_q;
            ax_s1_q <= {1'b0, I_A_XFER}; ax_s2_q <= ax_s1_q;
            bx_s1_q <= {1'b0, I_B_XFER}; bx_s2_q <= bx_s1_q;
            addr_s1_q <= I_ADDR; addr_s2_q <= addr_s1_q;
            wdata_s1_q <= I_WDATA; wdata_s2_q <= wdata_s1_q;
            a_pin_s1_q <= I_A_PIN_DATA; a_pin_s2_q <= a_pin_s1_q;
            b_pin_s1_q <= I_B_PIN_DATA; b_pin_s2_q <= b_pin_s1_q;
            a_par_s1_q <= I_A_PIN_PARITY; a_par_s2_q <= a_par_s1_q;
            b_par_s1_q <= I_B_PIN_PARITY; b_par_s2_q <= b_par_s1_q;
            wr_prev_q <= wr_s2_q[0];
            rd_prev_q <= rd_s2_q[0];
        end
    end

    // Decode: a write acts once, on the rising edge of the strobe.
    logic       wr_pulse;
    logic [4:0] eff_addr;
    logic       hi_byte;
    logic [4:0] word_addr;
    assign wr_pulse  = wr_s2_q[0] && !wr_prev_q;
    assign eff_addr  = {addr_s2_q[4:1], addr_s2_q[0] ^ swap_s2_q[0]};
    assign hi_byte   = eff_addr[0];
    assign word_addr = {eff_addr[4:1], 1'b0};

    // Command register and bank selection.
    logic [15:0] command_register;
    logic        cmd_commit;
    logic        cmd_reset;
    logic        cmd_new;
    logic        soft_clear;
    logic        wr_cmd;
    bank_t       bank_q;
    logic        cmd_lo_seen_q;

    assign wr_cmd     = wr_pulse && (word_addr == OFS_COMMAND_LOW);
    // The command acts when its high byte lands after the low one.
    assign cmd_commit = wr_cmd && hi_byte && cmd_lo_seen_q;
    assign cmd_reset  = cmd_commit && (wdata_s2_q == CMD_RESET);
    assign cmd_new    = cmd_commit && (wdata_s2_q == CMD_NEW_TRANSFER);
    assign soft_clear = cmd_reset || cmd_new;

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            bank_q        <= BANK_STATUS;
            cmd_lo_seen_q <= 1'b0;
        end
        else
        begin
            if (wr_cmd)
                cmd_lo_seen_q <= !hi_byte;
            if (cmd_commit)
            begin
                // Any non-selection command returns the shared addresses to status.
                unique case (wdata_s2_q)
                    CMD_SELECT_A: bank_q <= BANK_PORT_A;
                    CMD_SELECT_B: bank_q <= BANK_PORT_B;
                    default:      bank_q <= BANK_STATUS;
                endcase
            end
        end
    end

    cmp_byte_pair u_command
    (
        .i_clk         (I_CLK),
        .i_rst_n       (I_RST_N),
        .i_clear       (1'b0),
        .i_clear_value (RST_COMMAND),
        .i_wr          (wr_cmd),
        .i_hi          (hi_byte),
        .i_data        (wdata_s2_q),
        .o_value       (command_register)
    );

    // Bank-qualified write strobes.
    logic in_a, in_b;
    logic wr_cfg_a, wr_cfg_b, wr_pol_a, wr_pol_b;
    logic wr_rec, wr_cmp, wr_fifo, wr_fctl;
    assign in_a     = bank_q == BANK_PORT_A;
    assign in_b     = bank_q == BANK_PORT_B;
    assign wr_cfg_a = wr_pulse && in_a && (word_addr == OFS_STATUS_LOW);
    assign wr_cfg_b = wr_pulse && in_b && (word_addr == OFS_STATUS_LOW);
    // Polarity is one byte; the odd address beside it is reserved.
    assign wr_pol_a = wr_pulse && in_a && (eff_addr == OFS_IDENT_LOW);
    assign wr_pol_b = wr_pulse && in_b && (eff_addr == OFS_IDENT_LOW);
    assign wr_rec   = wr_pulse && in_a && (word_addr[4:2] == OFS_COUNT_BYTE2[4:2]);
    assign wr_cmp   = wr_pulse && in_b && (word_addr[4:2] == OFS_COUNT_BYTE2[4:2]);
    assign wr_fifo  = wr_pulse && in_a && (word_addr == OFS_GROUP8_LOW);
    assign wr_fctl  = wr_pulse && in_a && (eff_addr == OFS_GROUPA_LOW);

    // Configuration words: hardware reset only, kept over soft clears.
    logic [15:0] port_a_config, port_b_config;
    cmp_byte_pair u_cfg_a
    (
        .i_clk (I_CLK), .i_rst_n (I_RST_N), .i_clear (1'b0),
        .i_clear_value (RST_CONFIG), .i_wr (wr_cfg_a), .i_hi (hi_byte),
        .i_data (wdata_s2_q), .o_value (port_a_config)
    );
    cmp_byte_pair u_cfg_b
    (
        .i_clk (I_CLK), .i_rst_n (I_RST_N), .i_clear (1'b0),
        .i_clear_value (RST_CONFIG), .i_wr (wr_cfg_b), .i_hi (hi_byte),
        .i_data (wdata_s2_q), .o_value (port_b_config)
    );

    // FIFO data word, cleared by every reset type.
    logic [15:0] port_a_fifo_word;
    cmp_byte_pair u_fifo
    (
        .i_clk (I_CLK), .i_rst_n (I_RST_N), .i_clear (soft_clear),
        .i_clear_value (RST_FIFO_WORD), .i_wr (wr_fifo), .i_hi (hi_byte),
        .i_data (wdata_s2_q), .o_value (port_a_fifo_word)
    );

    // Byte registers and counters.
    logic [7:0]  port_a_polarity_q, port_b_polarity_q, port_a_fifo_control_q;
    logic [31:0] port_a_count_q, port_b_count_q, records_q, port_b_compare_q;
    logic [1:0]  lane;
    assign lane = eff_addr[1:0] ^ 2'b10; // Byte 2 sits at offset 4, byte 0 at 6.

    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
        begin
            port_a_polarity_q     <= RST_PORT_A_POL;
            port_b_polarity_q     <= RST_PORT_B_POL;
            port_a_fifo_control_q <= RST_FIFO_CONTROL;
            port_a_count_q        <= RST_COUNT;
            port_b_count_q        <= RST_COUNT;
            records_q             <= RST_COUNT;
            port_b_compare_q      <= RST_COUNT;
        end
        else if (soft_clear)
        begin
            // Polarity survives soft clears like the configuration words.
            port_a_fifo_control_q <= RST_FIFO_CONTROL;
            port_a_count_q        <= RST_COUNT;
            port_b_count_q        <= RST_COUNT;
            records_q             <= RST_COUNT;
            port_b_compare_q      <= RST_COUNT;
        end
        else
        begin
            if (wr_pol_a) port_a_polarity_q <= wdata_s2_q;
            if (wr_pol_b) port_b_polarity_q <= wdata_s2_q;
            if (wr_fctl)  port_a_fifo_control_q <= wdata_s2_q;
            if (wr_rec)   records_q[lane*8 +: 8] <= wdata_s2_q;
            if (wr_cmp)   port_b_compare_q[lane*8 +: 8] <= wdata_s2_q;
            if (ax_s2_q[0]) port_a_count_q <= port_a_count_q + 32'h0000_0002;
            if (bx_s2_q[0]) port_b_count_q <= port_b_count_q + 32'h0000_0002;
        end
    end

    // Read mux; anything not decoded reads zero.
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = 8'h00;
        unique case (bank_q)
            BANK_STATUS:
            begin
                if (eff_addr == OFS_STATUS_HIGH) rd_byte = RST_STATUS_HIGH;
                if (eff_addr == OFS_IDENT_LOW)   rd_byte = IDENT_LOW_VALUE;
                if (eff_addr == OFS_IDENT_HIGH)  rd_byte = IDENT_HIGH_VALUE;
                if (word_addr[4:2] == OFS_COUNT_BYTE2[4:2])
                    rd_byte = port_a_count_q[lane*8 +: 8];
                if (word_addr[4:2] == OFS_GROUP8_LOW[4:2])
                    rd_byte = port_b_count_q[lane*8 +: 8];
            end
            BANK_PORT_A:
            begin
                if (word_addr == OFS_STATUS_LOW) rd_byte = port_a_config[hi_byte*8 +: 8];
                if (eff_addr == OFS_IDENT_LOW)   rd_byte = port_a_polarity_q;
                if (word_addr[4:2] == OFS_COUNT_BYTE2[4:2]) rd_byte = records_q[lane*8 +: 8];
                if (word_addr == OFS_GROUP8_LOW) rd_byte = port_a_fifo_word[hi_byte*8 +: 8];
                if (eff_addr == OFS_GROUPA_LOW)  rd_byte = port_a_fifo_control_q;
            end
            BANK_PORT_B:
            begin
                if (word_addr == OFS_STATUS_LOW) rd_byte = port_b_config[hi_byte*8 +: 8];
                if (eff_addr == OFS_IDENT_LOW)   rd_byte = port_b_polarity_q;
                if (word_addr[4:2] == OFS_COUNT_BYTE2[4:2])
                    rd_byte = port_b_compare_q[lane*8 +: 8];
            end
        endcase
        if (word_addr == OFS_COMMAND_LOW) rd_byte = command_register[hi_byte*8 +: 8];
    end

    // Read data is registered so the output comes straight from a flop.
    always_ff @(posedge I_CLK)
    begin
        if (!I_RST_N)
            O_RDATA <= 8'h00;
        else if (rd_s2_q[0] && !rd_prev_q)
            O_RDATA <= rd_byte;
    end

    // The two data ports, fed back with the FIFO word as drive data.
    cmp_parity_port u_port_a
    (
        .i_clk (I_CLK), .i_rst_n (I_RST_N), .i_config (port_a_config),
        .i_polarity (port_a_polarity_q), .i_out_data (port_a_fifo_word),
        .i_pin_data (a_pin_s2_q), .i_pin_parity (a_par_s2_q),
        .o_pin_data (O_A_PIN_DATA), .o_pin_parity (O_A_PIN_PARITY),
        .o_pin_oe (O_A_PIN_OE), .o_parity_error (O_PARITY_ERROR[0])
    );
    cmp_parity_port u_port_b
    (
        .i_clk (I_CLK), .i_rst_n (I_RST_N), .i_config (port_b_config),
        .i_polarity (port_b_polarity_q), .i_out_data (port_a_fifo_word),
        .i_pin_data (b_pin_s2_q), .i_pin_parity (b_par_s2_q),
        .o_pin_data (O_B_PIN_DATA), .o_pin_parity (O_B_PIN_PARITY),
        .o_pin_oe (O_B_PIN_OE), .o_parity_error (O_PARITY_ERROR[1])
    );
endmodule // cmp_reg_bank

// file: verif/cmp_reg_bank_asserts.sv
// Checker for the coprocessor register bank, watching its top-level ports.
// Assumes strobes and reset change on the rising clock edge.
`timescale 1ns/10ps
module cmp_reg_bank_asserts
(
    input  wire logic        I_CLK,
    input  wire logic        I_RST_N,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    input  wire logic [7:0]  O_RDATA,
    input  wire logic [15:0] O_A_PIN_DATA,
    input  wire logic [1:0]  O_A_PIN_PARITY,
    input  wire logic        O_A_PIN_OE,
    input  wire logic [15:0] O_B_PIN_DATA,
    input  wire logic [1:0]  O_B_PIN_PARITY,
    input  wire logic        O_B_PIN_OE,
    input  wire logic [1:0]  O_PARITY_ERROR
);
    logic [7:0] wr_hist_q;
    logic [7:0] rd_hist_q;

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    // Strobe history; the synchroniser delays every effect by several cycles.
    always_ff @(posedge I_CLK)
    begin
        wr_hist_q <= I_RST_N ? {wr_hist_q[6:0], I_WR} : 8'h00;
        rd_hist_q <= I_RST_N ? {rd_hist_q[6:0], I_RD} : 8'h00;
    end

    a_reset_clean: assert property ($rose(I_RST_N) |-> O_RDATA == 8'h00 && !O_A_PIN_OE && !O_B_PIN_OE)
        else $error("outputs not clear after reset");
    a_rdata_by_read: assert property ($changed(O_RDATA) |-> |rd_hist_q[5:0])
        else $error("read data moved without a read");
    a_a_oe_by_write: assert property ($changed(O_A_PIN_OE) |-> |wr_hist_q[5:1])
        else $error("port A direction moved without a write");
    a_b_oe_by_write: assert property ($changed(O_B_PIN_OE) |-> |wr_hist_q[5:1])
        else $error("port B direction moved without a write");
    a_a_drive_by_write: assert property ($changed(O_A_PIN_DATA) |-> |wr_hist_q[5:1])
        else $error("port A drive word moved without a write");
    a_a_parity_sense: assert property ((^O_A_PIN_DATA[7:0] ^ O_A_PIN_PARITY[0]) == (^O_A_PIN_DATA[15:8] ^ O_A_PIN_PARITY[1]))
        else $error("port A byte parities disagree");
    a_b_parity_sense: assert property ((^O_B_PIN_DATA[7:0] ^ O_B_PIN_PARITY[0]) == (^O_B_PIN_DATA[15:8] ^ O_B_PIN_PARITY[1]))
        else $error("port B byte parities disagree");
    a_a_err_recv: assert property (O_PARITY_ERROR[0] |-> !O_A_PIN_OE || !$past(O_A_PIN_OE))
        else $error("port A parity error while driving");
    a_b_err_recv: assert property (O_PARITY_ERROR[1] |-> !O_B_PIN_OE || !$past(O_B_PIN_OE))
        else $error("port B parity error while driving");
endmodule // cmp_reg_bank_asserts

bind cmp_reg_bank cmp_reg_bank_asserts u_chk (.I_CLK, .I_RST_N, .I_WR, .I_RD, .O_RDATA,
    .O_A_PIN_DATA, .O_A_PIN_PARITY, .O_A_PIN_OE, .O_B_PIN_DATA, .O_B_PIN_PARITY,
    .O_B_PIN_OE, .O_PARITY_ERROR);

// file: verif/cmp_port_peer.sv
// Far-side peer of one data port, sending words with odd parity per byte.
// Assumes the port's output enable shows when the block owns the pins.
`timescale 1ns/10ps
module cmp_port_peer
(
    input  wire logic        i_clk,
    input  wire logic        i_oe,
    input  wire logic [15:0] i_word,
    input  wire logic        i_bad,
    output logic      [15:0] o_data,
    output logic      [1:0]  o_parity
);
    initial
    begin
        o_data   = 16'h0000;
        o_parity = 2'b00;
    end

    // A released bus toggles, so a stale value can never pass for data.
    always @(posedge i_clk)
    begin
        if (i_oe)
        begin
            o_data   <= ~o_data;
            o_parity <= ~o_parity;
        end
        else
        begin
            o_data   <= i_word;
            o_parity <= {~^i_word[15:8], (~^i_word[7:0]) ^ i_bad};
        end
    end
endmodule // cmp_port_peer

// file: verif/test_cmp_reg_bank.sv
// Self-checking bench for the register bank, with a peer on each data port.
// Assumes the register bank checker is bound in by its own file.
`timescale 1ns/10ps
module test_cmp_reg_bank;
    import cmp_regs_pkg::*;
    logic        clk, rst_n, wr, rd, swap, ax, bx, bad_a, bad_b, aoe, boe;
    logic [4:0]  addr;
    logic [7:0]  wd, rdata;
    logic [15:0] apd, bpd, aod, bod;
    logic [1:0]  app, bpp, aop, bop, perr;
    logic [7:0]  cmds [2] = '{CMD_RESET, CMD_NEW_TRANSFER};
    int          err_total, n_tests;

    cmp_reg_bank dut (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wd), .I_WR(wr),
        .I_RD(rd), .I_ADDRESS_SWAP_MODE(swap), .I_A_XFER(ax), .I_B_XFER(bx),
        .I_A_PIN_DATA(apd), .I_A_PIN_PARITY(app), .I_B_PIN_DATA(bpd), .I_B_PIN_PARITY(bpp),
        .O_RDATA(rdata), .O_A_PIN_DATA(aod), .O_A_PIN_PARITY(aop), .O_A_PIN_OE(aoe),
        .O_B_PIN_DATA(bod), .O_B_PIN_PARITY(bop), .O_B_PIN_OE(boe), .O_PARITY_ERROR(perr));
    cmp_port_peer peer_a (.i_clk(clk), .i_oe(aoe), .i_word(16'h1234), .i_bad(bad_a),
        .o_data(apd), .o_parity(app));
    cmp_port_peer peer_b (.i_clk(clk), .i_oe(boe), .i_word(16'h0f0f), .i_bad(bad_b),
        .o_data(bpd), .o_parity(bpp));

    // Free-running 100 MHz clock.
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Write strobes last four cycles, read strobes six, so the synchroniser surely sees them.
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        tick(4);
        wr <= 1'b0;
        tick(4);
    endtask

    task automatic rd_reg(input logic [4:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        tick(6);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdata});
        tick(4);
    endtask

    task automatic cmd(input logic [7:0] c);
        wr_reg(OFS_COMMAND_LOW, 8'h00);
        wr_reg(OFS_COMMAND_HIGH, c);
    endtask

    task automatic xfer(input logic b, input int n);
        @(posedge clk);
        ax <= !b;
        bx <= b;
        tick(n);
        ax <= 1'b0;
        bx <= 1'b0;
        tick(4);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // A hang is cut off well past the roughly 1200 cycles the tests need.
    initial
    begin
        #300000;
        err_total++;
        end_of_test();
    end

    initial
    begin
        {rst_n, wr, rd, swap, ax, bx, bad_a, bad_b, addr, wd} = '0;
        tick(3);
        rst_n <= 1'b1;
        for (int a = 0; a < 12; a++)
            rd_reg(5'(a), a == 1 ? RST_STATUS_HIGH : a == 2 ? IDENT_LOW_VALUE : a == 3 ? IDENT_HIGH_VALUE : 8'h00);
        cmd(CMD_SELECT_A);
        rd_reg(5'h00, 8'h00);
        rd_reg(5'h02, RST_PORT_A_POL);
        rd_reg(5'h03, 8'h00);
        cmd(CMD_SELECT_B);
        rd_reg(5'h02, RST_PORT_B_POL);
        $display("test reset values done");
        for (int p = 0; p < 4; p++)
        begin
            @(posedge clk);
            bad_a <= p[0];
            bad_b <= p[1];
            tick(6);
            #1;
            chk("parity error", 16'(p), {14'h0, perr});
        end
        @(posedge clk);
        {bad_a, bad_b} <= 2'b00;
        $display("test parity check done");
        cmd(CMD_SELECT_A);
        wr_reg(5'h00, 8'h35);
        rd_reg(5'h00, 8'h00);
        wr_reg(5'h01, 8'h12);
        rd_reg(5'h00, 8'h35);
        rd_reg(5'h01, 8'h12);
        wr_reg(5'h08, 8'h3c);
        wr_reg(5'h09, 8'ha4);
        rd_reg(5'h08, 8'h3c);
        chk("a drive", 16'ha43c, aod);
        chk("a parity", {14'h0, ~^8'ha4, ~^8'h3c}, {14'h0, aop});
        chk("a oe and error", 16'h0002, {14'h0, aoe, perr[0]});
        chk("b drive", 16'ha43c, bod);
        chk("b parity and oe", {13'h0, ~^8'ha4, ~^8'h3c, 1'b0}, {13'h0, bop, boe});
        @(posedge clk);
        swap <= 1'b1;
        rd_reg(5'h01, 8'h35);
        rd_reg(5'h00, 8'h12);
        @(posedge clk);
        swap <= 1'b0;
        wr_reg(5'h03, 8'h77);
        rd_reg(5'h03, 8'h00);
        wr_reg(5'h12, 8'h55);
        rd_reg(5'h12, 8'h00);
        rd_reg(5'h00, 8'h35);
        cmd(CMD_SELECT_B);
        wr_reg(5'h00, 8'h02);
        wr_reg(5'h01, 8'h80);
        rd_reg(5'h00, 8'h02);
        cmd(8'h00);
        rd_reg(5'h00, RST_STATUS_LOW);
        rd_reg(5'h01, RST_STATUS_HIGH);
        $display("test banks and pairing done");
        foreach (cmds[i])
        begin
            cmd(CMD_SELECT_A);
            wr_reg(5'h04, 8'h11);
            wr_reg(5'h06, 8'h22);
            wr_reg(5'h08, 8'h77);
            wr_reg(5'h09, 8'h66);
            rd_reg(5'h04, 8'h11);
            rd_reg(5'h06, 8'h22);
            cmd(CMD_SELECT_B);
            wr_reg(5'h05, 8'h33);
            rd_reg(5'h05, 8'h33);
            xfer(1'b0, 3);
            xfer(1'b1, 5);
            cmd(8'h00);
            rd_reg(5'h06, 8'h06);
            rd_reg(5'h0a, 8'h0a);
            cmd(cmds[i]);
            rd_reg(5'h06, 8'h00);
            rd_reg(5'h0a, 8'h00);
            cmd(CMD_SELECT_A);
            rd_reg(5'h04, 8'h00);
            rd_reg(5'h06, 8'h00);
            rd_reg(5'h08, 8'h00);
            rd_reg(5'h00, 8'h35);
            chk("a drive", RST_FIFO_WORD, aod);
            cmd(CMD_SELECT_B);
            rd_reg(5'h05, 8'h00);
            rd_reg(5'h01, 8'h80);
        end
        $display("test reset commands done");
        @(posedge clk);
        rst_n <= 1'b0;
        tick(3);
        rst_n <= 1'b1;
        cmd(CMD_SELECT_A);
        rd_reg(5'h00, 8'h00);
        chk("a oe", 16'h0000, {15'h0, aoe});
        $display("test hardware reset done");
        end_of_test();
    end
endmodule // test_cmp_reg_bank
